// [core/usu_uart.sv]
// Purpose: uart personality of a multi-protocol serial unit with apb registers
// Assumes: zero-wait apb slave; read data captured in the setup cycle
// Notes: UNIT selects which instance's register indices are decoded
//
// The implementer's own choice: the APB register port.
`timescale 1ns/10ps
`default_nettype none
module usu_uart #(
  parameter int UNIT = 0,
  parameter int PADDR_W = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [PADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  output logic serial_tx_pin,
  input wire logic serial_rx_pin_in,
  output logic serial_rx_pin_out,
  output logic serial_rx_pin_oe
);

  generate
    if (UNIT < 0 || UNIT > 2 || PADDR_W < 10) begin : g_chk
      $error("usu_uart: UNIT must be 0..2 and PADDR_W at least 10");
    end
  endgenerate

  localparam logic [7:0] CTRL_IDX = (UNIT == 0) ? usu_pkg::CTRL_IDX_U0 :
                                    (UNIT == 1) ? usu_pkg::CTRL_IDX_U1 : usu_pkg::CTRL_IDX_UX;
  localparam logic [7:0] DIVL_IDX = (UNIT == 0) ? usu_pkg::DIVL_IDX_U0 :
                                    (UNIT == 1) ? usu_pkg::DIVL_IDX_U1 : usu_pkg::DIVL_IDX_UX;
  localparam logic [7:0] DIVH_IDX = (UNIT == 0) ? usu_pkg::DIVH_IDX_U0 :
                                    (UNIT == 1) ? usu_pkg::DIVH_IDX_U1 : usu_pkg::DIVH_IDX_UX;
  localparam logic [7:0] DATA_IDX = (UNIT == 0) ? usu_pkg::DATA_IDX_U0 :
                                    (UNIT == 1) ? usu_pkg::DATA_IDX_U1 : usu_pkg::DATA_IDX_UX;

  ////////////////////////////////////////////////////////////////////////////
  // apb decode

  logic [PADDR_W-3:0] word;
  logic hit_ctrl, hit_divl, hit_divh, hit_data, hit_fsel, hit_any;
  logic wr_en, rd_setup;
  logic wr_ctrl, wr_divl, wr_divh, wr_data, wr_fsel;

  assign word = paddr[PADDR_W-1:2];
  assign hit_ctrl = word == (PADDR_W-2)'(CTRL_IDX);
  assign hit_divl = word == (PADDR_W-2)'(DIVL_IDX);
  assign hit_divh = word == (PADDR_W-2)'(DIVH_IDX);
  assign hit_data = word == (PADDR_W-2)'(DATA_IDX);
  assign hit_fsel = word == (PADDR_W-2)'(usu_pkg::FSEL_IDX);
  assign hit_any = hit_ctrl | hit_divl | hit_divh | hit_data | hit_fsel;
  assign wr_en = psel && penable && pwrite && pstrb[0];
  assign rd_setup = psel && !penable && !pwrite;
  assign wr_ctrl = wr_en && hit_ctrl;
  assign wr_divl = wr_en && hit_divl;
  assign wr_divh = wr_en && hit_divh;
  assign wr_data = wr_en && hit_data;
  assign wr_fsel = wr_en && hit_fsel;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit_any;

  ////////////////////////////////////////////////////////////////////////////
  // registers

  logic [1:0] mode_r, fsel_r;
  logic filt_r, ren_r, tx9_r, rx9_r, ti_r, ri_r;
  logic [15:0] div_r;
  logic [7:0] rxbuf_r;
  logic [31:0] prdata_r;
  logic uart_on;
  usu_pkg::usu_mode_t mode;
  logic tx_done, rx_done, rx_ri_set, rx_ninth;
  logic [7:0] rx_byte;
  logic [7:0] ctrl_rd;

  assign uart_on = fsel_r == usu_pkg::FSEL_UART;
  assign mode = usu_pkg::usu_mode_t'(mode_r);
  assign ctrl_rd = {mode_r, filt_r, ren_r, tx9_r, rx9_r, ti_r, ri_r};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fsel_r <= usu_pkg::FSEL_RST;
    end else if (wr_fsel) begin
      fsel_r <= pwdata[1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r <= usu_pkg::CTRL_RST[usu_pkg::MODE_HI_BIT:usu_pkg::MODE_LO_BIT];
      filt_r <= usu_pkg::CTRL_RST[usu_pkg::FILT_BIT];
      ren_r <= usu_pkg::CTRL_RST[usu_pkg::REN_BIT];
      tx9_r <= usu_pkg::CTRL_RST[usu_pkg::TX9_BIT];
    end else if (wr_ctrl) begin
      mode_r <= pwdata[usu_pkg::MODE_HI_BIT:usu_pkg::MODE_LO_BIT];
      filt_r <= pwdata[usu_pkg::FILT_BIT];
      ren_r <= pwdata[usu_pkg::REN_BIT];
      tx9_r <= pwdata[usu_pkg::TX9_BIT];
    end
  end

  // flags: hardware set wins over write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ti_r <= usu_pkg::CTRL_RST[usu_pkg::TI_BIT];
      ri_r <= usu_pkg::CTRL_RST[usu_pkg::RI_BIT];
    end else begin
      ti_r <= tx_done | (ti_r & !(wr_ctrl & pwdata[usu_pkg::TI_BIT]));
      ri_r <= rx_ri_set | (ri_r & !(wr_ctrl & pwdata[usu_pkg::RI_BIT]));
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx9_r <= usu_pkg::CTRL_RST[usu_pkg::RX9_BIT];
      rxbuf_r <= usu_pkg::DATA_RST;
    end else if (rx_done) begin
      rxbuf_r <= rx_byte;
      if (mode == usu_pkg::MODE_11BIT) begin
        rx9_r <= rx_ninth;
      end
    end else if (wr_ctrl) begin
      rx9_r <= pwdata[usu_pkg::RX9_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r <= usu_pkg::DIV_RST;
    end else begin
      if (wr_divl) begin
        div_r[7:0] <= pwdata[7:0];
      end
      if (wr_divh) begin
        div_r[15:8] <= pwdata[7:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= '0;
    end else if (rd_setup) begin
      prdata_r <= hit_ctrl ? {24'h000000, ctrl_rd} :
                  hit_divl ? {24'h000000, div_r[7:0]} :
                  hit_divh ? {24'h000000, div_r[15:8]} :
                  hit_data ? {24'h000000, rxbuf_r} :
                  hit_fsel ? {30'h00000000, fsel_r} : 32'h00000000;
    end
  end
  assign prdata = prdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // transmitter

  usu_pkg::usu_tx_state_t tx_state_r;
  logic [10:0] tx_sh_r;
  logic [3:0] tx_cnt_r, tx_len_r;
  logic tx_sync_r, tx_start, tx_tick, tx_late;
  logic [15:0] tx_div;
  usu_pkg::usu_rx_state_t rx_state_r;
  logic rx_sync_r;

  // shift mode is half duplex: no start while a shift receive runs
  assign tx_start = wr_data && uart_on && mode != usu_pkg::MODE_RSVD && tx_state_r == usu_pkg::TX_IDLE &&
                    !(mode == usu_pkg::MODE_SYNC && rx_state_r != usu_pkg::RX_IDLE);
  assign tx_div = tx_sync_r ? (filt_r ? usu_pkg::SYNC_FAST_DIV : usu_pkg::SYNC_SLOW_DIV) : div_r;
  assign tx_done = tx_state_r == usu_pkg::TX_SHIFT && tx_tick && tx_cnt_r == tx_len_r - 4'h1;

  usu_baud_gen #(.W(16)) u_tx_baud (
    .pclk(pclk),
    .presetn(presetn),
    .run(tx_state_r == usu_pkg::TX_SHIFT),
    .restart(tx_start),
    .div(tx_div),
    .mid(),
    .tick(tx_tick),
    .late(tx_late)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_state_r <= usu_pkg::TX_IDLE;
      tx_sh_r <= 11'h7FF;
      tx_cnt_r <= 4'h0;
      tx_len_r <= usu_pkg::LEN_10BIT;
      tx_sync_r <= 1'b0;
    end else if (tx_start) begin
      tx_state_r <= usu_pkg::TX_SHIFT;
      tx_cnt_r <= 4'h0;
      tx_sync_r <= mode == usu_pkg::MODE_SYNC;
      unique case (mode)
        usu_pkg::MODE_SYNC: begin
          tx_sh_r <= {3'h7, pwdata[7:0]};
          tx_len_r <= usu_pkg::LEN_SYNC;
        end
        usu_pkg::MODE_10BIT: begin
          tx_sh_r <= {2'h3, pwdata[7:0], 1'b0};
          tx_len_r <= usu_pkg::LEN_10BIT;
        end
        default: begin
          tx_sh_r <= {1'b1, tx9_r, pwdata[7:0], 1'b0};
          tx_len_r <= usu_pkg::LEN_11BIT;
        end
      endcase
    end else if (tx_state_r == usu_pkg::TX_SHIFT && tx_tick) begin
      tx_sh_r <= {1'b1, tx_sh_r[10:1]};
      tx_cnt_r <= tx_cnt_r + 4'h1;
      if (tx_done) begin
        tx_state_r <= usu_pkg::TX_IDLE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receiver

  logic rx_s1_r, rx_s2_r, rx_s3_r, rx_f_r, rx_fd_r;
  logic [8:0] rx_sh_r, rx_sh_nxt;
  logic [3:0] rx_cnt_r, rx_len_r;
  logic rx_mid, rx_tick, rx_late, rx_restart, rx_fall, rx_sample, rx_last;
  logic rx_go_async, rx_go_sync;
  logic [15:0] rx_div;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_s1_r <= 1'b1;
      rx_s2_r <= 1'b1;
      rx_s3_r <= 1'b1;
      rx_f_r <= 1'b1;
      rx_fd_r <= 1'b1;
    end else begin
      rx_s1_r <= serial_rx_pin_in;
      rx_s2_r <= rx_s1_r;
      rx_s3_r <= rx_s2_r;
      if (rx_s2_r == rx_s3_r) begin
        rx_f_r <= rx_s3_r;
      end
      rx_fd_r <= rx_f_r;
    end
  end

  assign rx_fall = rx_fd_r && !rx_f_r;
  assign rx_go_async = rx_state_r == usu_pkg::RX_IDLE && uart_on && ren_r && rx_fall &&
                       (mode == usu_pkg::MODE_10BIT || mode == usu_pkg::MODE_11BIT);
  assign rx_go_sync = rx_state_r == usu_pkg::RX_IDLE && uart_on && ren_r && !ri_r &&
                      mode == usu_pkg::MODE_SYNC && tx_state_r == usu_pkg::TX_IDLE && !tx_start;
  assign rx_restart = rx_go_async || rx_go_sync;
  assign rx_div = rx_sync_r ? (filt_r ? usu_pkg::SYNC_FAST_DIV : usu_pkg::SYNC_SLOW_DIV) : div_r;
  assign rx_sample = rx_state_r == usu_pkg::RX_DATA && (rx_sync_r ? rx_tick : rx_mid);
  assign rx_last = rx_sample && rx_cnt_r == rx_len_r - 4'h1;
  assign rx_sh_nxt = {rx_f_r, rx_sh_r[8:1]};
  assign rx_done = rx_last && ren_r;
  assign rx_byte = rx_sync_r ? rx_sh_nxt[8:1] :
                   (rx_len_r == usu_pkg::RXLEN_11BIT) ? rx_sh_r[7:0] : rx_sh_r[8:1];
  assign rx_ninth = rx_sh_r[8];
  assign rx_ri_set = rx_done && !(mode == usu_pkg::MODE_11BIT && filt_r && !rx_ninth);

  usu_baud_gen #(.W(16)) u_rx_baud (
    .pclk(pclk),
    .presetn(presetn),
    .run(rx_state_r != usu_pkg::RX_IDLE),
    .restart(rx_restart),
    .div(rx_div),
    .mid(rx_mid),
    .tick(rx_tick),
    .late(rx_late)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_state_r <= usu_pkg::RX_IDLE;
      rx_sh_r <= 9'h000;
      rx_cnt_r <= 4'h0;
      rx_len_r <= usu_pkg::RXLEN_10BIT;
      rx_sync_r <= 1'b0;
    end else if (rx_state_r != usu_pkg::RX_IDLE && (!ren_r || !uart_on)) begin
      rx_state_r <= usu_pkg::RX_IDLE;
    end else begin
      unique case (rx_state_r)
        usu_pkg::RX_IDLE: begin
          rx_cnt_r <= 4'h0;
          if (rx_go_async) begin
            rx_state_r <= usu_pkg::RX_START;
            rx_sync_r <= 1'b0;
            rx_len_r <= (mode == usu_pkg::MODE_11BIT) ? usu_pkg::RXLEN_11BIT : usu_pkg::RXLEN_10BIT;
          end else if (rx_go_sync) begin
            rx_state_r <= usu_pkg::RX_DATA;
            rx_sync_r <= 1'b1;
            rx_len_r <= usu_pkg::LEN_SYNC;
          end
        end
        usu_pkg::RX_START: begin
          // a start bit that is high again at mid-point was a glitch
          if (rx_mid) begin
            rx_state_r <= rx_f_r ? usu_pkg::RX_IDLE : usu_pkg::RX_DATA;
          end
        end
        usu_pkg::RX_DATA: begin
          if (rx_sample) begin
            rx_cnt_r <= rx_cnt_r + 4'h1;
            if (rx_sync_r || !rx_last) begin
              rx_sh_r <= rx_sh_nxt;
            end
            if (rx_last) begin
              rx_state_r <= usu_pkg::RX_IDLE;
            end
          end
        end
        default: begin
          rx_state_r <= usu_pkg::RX_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pins

  logic tx_pin_r, rx_out_r, rx_oe_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_pin_r <= 1'b1;
      rx_out_r <= 1'b1;
      rx_oe_r <= 1'b0;
    end else begin
      // shift clock is low in the first half of each bit
      if (!uart_on) begin
        tx_pin_r <= 1'b1;
      end else if (tx_state_r == usu_pkg::TX_SHIFT && tx_sync_r) begin
        tx_pin_r <= tx_late;
      end else if (rx_state_r == usu_pkg::RX_DATA && rx_sync_r) begin
        tx_pin_r <= rx_late;
      end else if (tx_state_r == usu_pkg::TX_SHIFT) begin
        tx_pin_r <= tx_sh_r[0];
      end else begin
        tx_pin_r <= 1'b1;
      end
      rx_oe_r <= uart_on && tx_state_r == usu_pkg::TX_SHIFT && tx_sync_r;
      rx_out_r <= tx_sh_r[0];
    end
  end

  assign serial_tx_pin = tx_pin_r;
  assign serial_rx_pin_out = rx_out_r;
  assign serial_rx_pin_oe = rx_oe_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  sequence s_async_load;
    tx_start && mode != usu_pkg::MODE_SYNC;
  endsequence

  sequence s_start_bit_out;
    ##2 (serial_tx_pin == 1'b0);
  endsequence

  ti_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_ctrl && pwdata[usu_pkg::TI_BIT] && !tx_done) |=> !ti_r) else $error("ti not cleared");
  ti_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ti_r && !(wr_ctrl && pwdata[usu_pkg::TI_BIT])) |=> ti_r) else $error("ti dropped without clear");
  tx_start_bit_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_async_load |-> s_start_bit_out) else $error("start bit not low");
  tx_ninth_a: assert property (@(posedge pclk) disable iff (!presetn)
    (tx_start && mode == usu_pkg::MODE_11BIT) |=> tx_sh_r[9] == $past(tx9_r)) else $error("ninth bit wrong");
  sync_oe_a: assert property (@(posedge pclk) disable iff (!presetn)
    (uart_on && tx_state_r == usu_pkg::TX_SHIFT && tx_sync_r) |=> serial_rx_pin_oe) else $error("rx pin not driven");
  sync_rate_a: assert property (@(posedge pclk) disable iff (!presetn)
    (tx_tick && tx_sync_r && !filt_r && !tx_done && !wr_ctrl) |-> ##12 tx_tick) else $error("slow shift rate wrong");
  rx_filter_a: assert property (@(posedge pclk) disable iff (!presetn)
    (rx_done && mode == usu_pkg::MODE_11BIT && filt_r && !rx_ninth && !ri_r) |=> !ri_r) else $error("filter failed");
  rx_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    (rx_done && mode == usu_pkg::MODE_11BIT && !filt_r) |=> ri_r && rx9_r == $past(rx_ninth)) else $error("no rx flag");
  ren_block_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!ren_r && rx_state_r == usu_pkg::RX_IDLE) |=> rx_state_r == usu_pkg::RX_IDLE) else $error("rx without enable");
  data_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_setup && hit_data) |=> prdata[7:0] == $past(rxbuf_r)) else $error("data read not latch");
  off_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
    !uart_on |=> serial_tx_pin) else $error("tx pin active while off");

endmodule
`default_nettype wire

// [pkg/usu_pkg.sv]
// Purpose: shared constants and types of the serial unit in uart personality
// Assumes: register indices are word indices; byte address is four times the index
// Notes: one package for the top and the bench
package usu_pkg;

  // register word indices, one set per instance, plus FSEL_IDX shared by all
  localparam logic [7:0] CTRL_IDX_U0 = 8'h95;
  localparam logic [7:0] DIVL_IDX_U0 = 8'h9D;
  localparam logic [7:0] DIVH_IDX_U0 = 8'h9E;
  localparam logic [7:0] DATA_IDX_U0 = 8'h9F;
  localparam logic [7:0] CTRL_IDX_U1 = 8'hA4;
  localparam logic [7:0] DIVL_IDX_U1 = 8'hA5;
  localparam logic [7:0] DIVH_IDX_U1 = 8'hA6;
  localparam logic [7:0] DATA_IDX_U1 = 8'hA7;
  localparam logic [7:0] CTRL_IDX_UX = 8'hC4;
  localparam logic [7:0] DIVL_IDX_UX = 8'hC5;
  localparam logic [7:0] DIVH_IDX_UX = 8'hC6;
  localparam logic [7:0] DATA_IDX_UX = 8'hC7;
  localparam logic [7:0] FSEL_IDX = 8'hF0;

  // control register fields
  localparam int MODE_HI_BIT = 7;
  localparam int MODE_LO_BIT = 6;
  localparam int FILT_BIT = 5;
  localparam int REN_BIT = 4;
  localparam int TX9_BIT = 3;
  localparam int RX9_BIT = 2;
  localparam int TI_BIT = 1;
  localparam int RI_BIT = 0;

  // reset values and the uart function select code
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [15:0] DIV_RST = 16'h0000;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [1:0] FSEL_RST = 2'h0;
  localparam logic [1:0] FSEL_UART = 2'h3;

  // shift-mode rate divisors and frame lengths
  localparam logic [15:0] SYNC_SLOW_DIV = 16'h000C;
  localparam logic [15:0] SYNC_FAST_DIV = 16'h0004;
  localparam logic [3:0] LEN_SYNC = 4'h8;
  localparam logic [3:0] LEN_10BIT = 4'hA;
  localparam logic [3:0] LEN_11BIT = 4'hB;
  localparam logic [3:0] RXLEN_10BIT = 4'h9;
  localparam logic [3:0] RXLEN_11BIT = 4'hA;

  typedef enum logic [1:0] {
    MODE_SYNC = 2'b00,
    MODE_10BIT = 2'b01,
    MODE_RSVD = 2'b10,
    MODE_11BIT = 2'b11
  } usu_mode_t;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_SHIFT = 2'b01
  } usu_tx_state_t;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_DATA = 2'b10
  } usu_rx_state_t;

endpackage

// [core/usu_baud_gen.sv]
// Purpose: bit-period divider with mid-point and end pulses
// Assumes: div of 0 or 1 gives a pulse every cycle
// Notes: restart clears the count so a bit period starts at once
`timescale 1ns/10ps
`default_nettype none
module usu_baud_gen #(
  parameter int W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic restart,
  input wire logic [W-1:0] div,
  output logic mid,
  output logic tick,
  output logic late
);

  logic [W-1:0] cnt_r;
  logic [W-1:0] last;
  logic [W-1:0] half;

  generate
    if (W < 2) begin : g_chk
      $error("usu_baud_gen: W must be at least 2");
    end
  endgenerate

  assign last = (div <= W'(1)) ? '0 : div - W'(1);
  assign half = div >> 1;
  assign tick = run && !restart && (cnt_r >= last);
  assign mid = run && !restart && (cnt_r == ((div <= W'(1)) ? '0 : half));
  assign late = cnt_r >= half;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
    end else if (restart || !run || tick) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + W'(1);
    end
  end

endmodule
`default_nettype wire

// [dv/usu_serial_peer.sv]
// Purpose: far-side serial device for the uart block
// Assumes: bit period given in pclk cycles by the caller
// Notes: line returns high (pull-up level) when released
`timescale 1ns/10ps
`default_nettype none
module usu_serial_peer (
  input wire logic pclk,
  input wire logic tx_line,
  output logic rx_line
);
  initial rx_line = 1'b1;
  ////////////////////////////////////////////////////////////
  // async frame, lsb first, start and stop inside bits
  task automatic send(input logic [10:0] bits, input int nbits, input int per);
    for (int i = 0; i < nbits; i++) begin
      rx_line <= bits[i];
      repeat (per) @(posedge pclk);
    end
    rx_line <= 1'b1;
  endtask
  // mid-bit sampling from the start edge
  task automatic grab(input int nbits, input int per, output logic [10:0] bits);
    bits = '0;
    @(negedge tx_line);
    repeat (per / 2) @(posedge pclk);
    for (int i = 0; i < nbits; i++) begin
      bits[i] = tx_line;
      repeat (per) @(posedge pclk);
    end
  endtask
  // shift-mode feed: next bit after each falling clock
  task automatic shift_feed(input logic [7:0] d);
    rx_line <= d[0];
    @(negedge tx_line);
    for (int i = 1; i < 8; i++) begin
      @(negedge tx_line);
      rx_line <= d[i];
    end
    @(posedge tx_line);
    repeat (8) @(posedge pclk);
    rx_line <= 1'b1;
  endtask
endmodule
`default_nettype wire

// [dv/tb_usu_uart.sv]
// Purpose: self-checking bench of the uart block, unit 0
// Assumes: zero-wait apb slave, byte address four times the index
// Notes: one task per scenario
`timescale 1ns/10ps
`default_nettype none
module tb_usu_uart;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic tx_pin, rx_out, rx_oe, peer_rx;
  wire logic rx_in = rx_oe ? rx_out : peer_rx;
  int bad_count = 0;
  int comparisons = 0;
  usu_uart #(.UNIT(0), .PADDR_W(12)) u_usu_uart (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .serial_tx_pin(tx_pin),
    .serial_rx_pin_in(rx_in), .serial_rx_pin_out(rx_out), .serial_rx_pin_oe(rx_oe));
  usu_serial_peer u_usu_serial_peer (.pclk(pclk), .tx_line(tx_pin), .rx_line(peer_rx));
  ////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic apb(input logic [7:0] idx, input logic w, input logic [7:0] wd,
                     output logic [31:0] r, output logic e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(idx, 1'b1, d, r, e);
  endtask
  task automatic rd(input logic [7:0] idx, output logic [31:0] r);
    logic e;
    apb(idx, 1'b0, 8'h00, r, e);
  endtask
  task automatic wait_ctrl(input int bitn);
    logic [31:0] r;
    r = '0;
    for (int i = 0; i < 400 && r[bitn] !== 1'b1; i++) rd(usu_pkg::CTRL_IDX_U0, r);
    check("flag", {31'h0, r[bitn]}, 32'h1);
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_regs();
    logic [31:0] r;
    logic e;
    logic low;
    logic [7:0] idx [4] = '{usu_pkg::CTRL_IDX_U0, usu_pkg::DIVL_IDX_U0, usu_pkg::DIVH_IDX_U0,
                            usu_pkg::DATA_IDX_U0};
    low = 1'b0;
    for (int i = 0; i < 4; i++) begin
      rd(idx[i], r);
      check("reset value", r, 32'h0);
    end
    apb(8'h10, 1'b0, 8'h00, r, e);
    check("unmapped err", {31'h0, e}, 32'h1);
    check("unmapped data", r, 32'h0);
    wr(usu_pkg::DIVH_IDX_U0, 8'h01);
    wr(usu_pkg::DIVL_IDX_U0, 8'h04);
    rd(usu_pkg::DIVH_IDX_U0, r);
    check("divisor high", r, 32'h1);
    wr(usu_pkg::DATA_IDX_U0, 8'h00);
    for (int i = 0; i < 100; i++) begin
      @(posedge pclk);
      if (tx_pin !== 1'b1 || rx_oe !== 1'b0) low = 1'b1;
    end
    check("unit off quiet", {31'h0, low}, 32'h0);
    wr(usu_pkg::FSEL_IDX, 8'h03);
  endtask
  task automatic t_async_tx();
    logic [10:0] b;
    logic [31:0] r;
    wr(usu_pkg::CTRL_IDX_U0, 8'h50);
    fork
      u_usu_serial_peer.grab(10, 260, b);
      wr(usu_pkg::DATA_IDX_U0, 8'hA5);
    join
    check("mode01 frame", b, {1'b1, 8'hA5, 1'b0});
    wait_ctrl(1);
    repeat (50) @(posedge pclk);
    rd(usu_pkg::CTRL_IDX_U0, r);
    check("ti held", r, 32'h52);
    wr(usu_pkg::CTRL_IDX_U0, 8'h52);
    rd(usu_pkg::CTRL_IDX_U0, r);
    check("ti cleared", r, 32'h50);
    wr(usu_pkg::DIVH_IDX_U0, 8'h00);
    wr(usu_pkg::DIVL_IDX_U0, 8'h08);
  endtask
  task automatic t_duplex();
    logic [10:0] b;
    logic [31:0] r;
    fork
      u_usu_serial_peer.send({1'b1, 8'h3C, 1'b0}, 10, 8);
      wr(usu_pkg::DATA_IDX_U0, 8'h5A);
      u_usu_serial_peer.grab(10, 8, b);
    join
    check("duplex tx", b, {1'b1, 8'h5A, 1'b0});
    wait_ctrl(0);
    rd(usu_pkg::DATA_IDX_U0, r);
    check("rx latch", r, 32'h3C);
    wr(usu_pkg::CTRL_IDX_U0, 8'h53);
  endtask
  task automatic rx11(input logic [8:0] d, input logic [7:0] ctl, input logic [7:0] ed);
    logic [31:0] r;
    u_usu_serial_peer.send({1'b1, d, 1'b0}, 11, 8);
    repeat (20) @(posedge pclk);
    rd(usu_pkg::CTRL_IDX_U0, r);
    check("mode11 status", r, {24'h0, ctl});
    rd(usu_pkg::DATA_IDX_U0, r);
    check("mode11 data", r, {24'h0, ed});
  endtask
  task automatic t_mode11();
    logic [10:0] b;
    wr(usu_pkg::CTRL_IDX_U0, 8'hD8);
    fork
      u_usu_serial_peer.grab(11, 8, b);
      wr(usu_pkg::DATA_IDX_U0, 8'h81);
    join
    check("mode11 frame", b, {2'b11, 8'h81, 1'b0});
    wait_ctrl(1);
    wr(usu_pkg::CTRL_IDX_U0, 8'hDA);
    rx11({1'b1, 8'h96}, 8'hDD, 8'h96);
    wr(usu_pkg::CTRL_IDX_U0, 8'hF9);
    rx11({1'b0, 8'h33}, 8'hF8, 8'h33);
    rx11({1'b1, 8'h44}, 8'hFD, 8'h44);
    wr(usu_pkg::CTRL_IDX_U0, 8'h41);
    // receive disabled: latch keeps the previous byte
    rx11({1'b1, 8'h77}, 8'h40, 8'h44);
  endtask
  task automatic t_shift_tx(input logic [7:0] ctl, input int per);
    logic [7:0] got;
    longint t0;
    longint n;
    got = '0;
    n = 0;
    wr(usu_pkg::CTRL_IDX_U0, ctl);
    fork
      wr(usu_pkg::DATA_IDX_U0, 8'h6C);
      for (int i = 0; i < 8; i++) begin
        @(negedge tx_pin);
        if (i == 0) t0 = $time;
        if (i == 1) n = ($time - t0) / 20;
        @(posedge tx_pin);
        got[i] = rx_oe ? rx_out : 1'bx;
      end
    join
    check("shift data", got, 8'h6C);
    check("shift period", n, per);
    wait_ctrl(1);
    wr(usu_pkg::CTRL_IDX_U0, ctl | 8'h02);
  endtask
  task automatic t_shift_rx();
    logic [31:0] r;
    fork
      u_usu_serial_peer.shift_feed(8'hB2);
      wr(usu_pkg::CTRL_IDX_U0, 8'h10);
    join
    wait_ctrl(0);
    rd(usu_pkg::DATA_IDX_U0, r);
    check("shift rx", r, 32'hB2);
    wr(usu_pkg::CTRL_IDX_U0, 8'h01);
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  initial begin
    repeat (40000) @(posedge pclk);
    bad_count++;
    finish_test();
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_async_tx();
    t_duplex();
    t_mode11();
    t_shift_tx(8'h00, 12);
    t_shift_tx(8'h20, 4);
    t_shift_rx();
    finish_test();
  end
endmodule
`default_nettype wire
